// file: src/imqp_port.sv
/*
  Message-queue register port: host register writes to the two queue
  registers become local-bus writes to post lists; nothing fills the free lists, so queue register reads answer all ones.
  Assumes a simple synchronous host register port and a local memory port
  with a request/acknowledge handshake; list placement given as inputs.
*/
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module imqp_port #(
  parameter int AW    = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          arst_n,
  // host register port
  input  wire logic          reg_sel,
  input  wire logic          reg_wr,
  input  wire logic [11:0]   reg_addr,
  input  wire logic [31:0]   reg_wdata,
  output logic               reg_done,
  output logic               reg_retry,
  output logic [31:0]        reg_rdata,
  // list placement
  input  wire logic [AW-1:0] in_post_base,
  input  wire logic [AW-1:0] in_free_base,
  input  wire logic [AW-1:0] out_post_base,
  input  wire logic [AW-1:0] out_free_base,
  // local memory port
  output logic               mem_req,
  output logic               mem_wr,
  output logic [AW-1:0]      mem_addr,
  output logic [31:0]        mem_wdata,
  input  wire logic          mem_ack,
  input  wire logic [31:0]   mem_rdata,
  // interrupt
  output logic               outpost_irq
);
  localparam int PW = $clog2(DEPTH);
  typedef enum logic [1:0] {
    IMQP_IDLE = 2'b00,
    IMQP_WR   = 2'b01,
    IMQP_RD   = 2'b10
  } imqp_state_t;

  imqp_state_t   state;
  logic [PW-1:0] ptr [4];
  logic [PW:0]   fill [4];
  logic          outpost_irq_mask;
  logic          pend_in;
  logic          pend_out;
  logic          rd_list_out;
  logic          is_inq;
  logic          is_outq;
  logic          hit_pend;
  logic          buf_in_ready;
  logic          buf_valid;
  logic [32:0]   buf_data;
  logic          next_buf_valid;
  logic          wr_done;
  logic [1:0]    wr_list;
  logic          outpost_service_request;

  assign is_inq   = reg_sel && (reg_addr == imqp_pkg::OFF_INQ);
  assign is_outq  = reg_sel && (reg_addr == imqp_pkg::OFF_OUTQ);
  assign hit_pend = (is_inq && pend_in) || (is_outq && pend_out);
  assign next_buf_valid = reg_sel && reg_wr && !hit_pend && !reg_retry && !reg_done
                          && (is_inq || is_outq) && buf_in_ready;
  assign wr_done  = (state == IMQP_WR) && mem_ack;
  assign wr_list  = buf_data[32] ? imqp_pkg::LIST_OUT_POST : imqp_pkg::LIST_IN_POST;
  assign outpost_service_request = (fill[imqp_pkg::LIST_OUT_POST] != '0);

  imqp_buf2 #(.W(33)) u_buf (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_valid  (next_buf_valid),
    .in_ready  (buf_in_ready),
    .in_data   ({is_outq, reg_wdata}),
    .out_valid (buf_valid),
    .out_ready (wr_done),
    .out_data  (buf_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // pending flags per queue register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_in  <= 1'h0;
      pend_out <= 1'h0;
    end
    else
    begin
      // cleared when local write completes; new post wins
      if (wr_done && !buf_data[32])
        pend_in <= 1'h0;
      if (wr_done && buf_data[32])
        pend_out <= 1'h0;
      if (next_buf_valid && is_inq)
        pend_in <= 1'h1;
      if (next_buf_valid && is_outq)
        pend_out <= 1'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // local memory sequencer
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state       <= IMQP_IDLE;
      mem_req     <= 1'h0;
      mem_wr      <= 1'h0;
      mem_addr    <= '0;
      mem_wdata   <= imqp_pkg::RST_WORD;
      rd_list_out <= 1'h0;
    end
    else
    begin
      unique case (state)
        IMQP_IDLE:
        begin
          if (buf_valid)
          begin
            // write word at post list top
            state     <= IMQP_WR;
            mem_req   <= 1'h1;
            mem_wr    <= 1'h1;
            mem_wdata <= buf_data[31:0];
            mem_addr  <= (buf_data[32] ? out_post_base : in_post_base)
                         + AW'({ptr[wr_list], 2'h0});
          end
          else if (reg_sel && !reg_wr && !reg_done && !reg_retry && !hit_pend
                   && (is_inq || is_outq)
                   && fill[is_outq ? imqp_pkg::LIST_OUT_FREE : imqp_pkg::LIST_IN_FREE] != '0)
          begin
            state       <= IMQP_RD;
            mem_req     <= 1'h1;
            mem_wr      <= 1'h0;
            rd_list_out <= is_outq;
            mem_addr    <= (is_outq ? out_free_base : in_free_base)
                           + AW'({ptr[is_outq ? imqp_pkg::LIST_OUT_FREE
                                              : imqp_pkg::LIST_IN_FREE], 2'h0});
          end
        end
        IMQP_WR, IMQP_RD:
        begin
          if (mem_ack)
          begin
            state   <= IMQP_IDLE;
            mem_req <= 1'h0;
            mem_wr  <= 1'h0;
          end
        end
        default:
          state <= IMQP_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // list pointers and occupancy
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 4; i++)
      begin
        ptr[i]  <= '0;
        fill[i] <= '0;
      end
    end
    else
    begin
      // advance top after write, wraps at list depth
      if (wr_done)
      begin
        ptr[wr_list] <= ptr[wr_list] + PW'(1);
        if (fill[wr_list] != (PW+1)'(DEPTH))
          fill[wr_list] <= fill[wr_list] + (PW+1)'(1);
      end
      if ((state == IMQP_RD) && mem_ack)
      begin
        ptr[{rd_list_out, 1'h1}]  <= ptr[{rd_list_out, 1'h1}] + PW'(1);
        fill[{rd_list_out, 1'h1}] <= fill[{rd_list_out, 1'h1}] - (PW+1)'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // host register answers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_done  <= 1'h0;
      reg_retry <= 1'h0;
      reg_rdata <= imqp_pkg::RST_WORD;
    end
    else
    begin
      reg_done  <= 1'h0;
      reg_retry <= 1'h0;
      reg_rdata <= imqp_pkg::RST_WORD;
      if (reg_sel && !reg_done && !reg_retry)
      begin
        if ((is_inq || is_outq) && (hit_pend || (reg_wr && !buf_in_ready)))
          reg_retry <= 1'h1;
        else if ((is_inq || is_outq) && reg_wr)
          reg_done <= 1'h1;
        else if (is_inq || is_outq)
        begin
          if (fill[is_outq ? imqp_pkg::LIST_OUT_FREE : imqp_pkg::LIST_IN_FREE] == '0)
          begin
            // empty free list reads all ones
            reg_done  <= 1'h1;
            reg_rdata <= imqp_pkg::EMPTY_WORD;
          end
          else if ((state == IMQP_RD) && mem_ack)
          begin
            reg_done  <= 1'h1;
            reg_rdata <= mem_rdata;
          end
        end
        else
        begin
          reg_done <= 1'h1;
          if (reg_addr == imqp_pkg::OFF_OP_STATUS)
            reg_rdata[imqp_pkg::BIT_OP_SR] <= outpost_service_request;
          else if (reg_addr == imqp_pkg::OFF_OP_MASK)
            reg_rdata[imqp_pkg::BIT_OUTPOST_IRQ_MASK] <= outpost_irq_mask;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt mask and request
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      outpost_irq_mask <= imqp_pkg::RST_OUTPOST_IRQ_MASK;
      outpost_irq      <= 1'h0;
    end
    else
    begin
      if (reg_sel && reg_wr && !reg_done && reg_addr == imqp_pkg::OFF_OP_MASK)
        outpost_irq_mask <= reg_wdata[imqp_pkg::BIT_OUTPOST_IRQ_MASK];
      outpost_irq <= outpost_service_request && !outpost_irq_mask;
    end
  end
endmodule
`default_nettype wire

// file: src/imqp_pkg.sv
/*
  Package for the message-queue register port: register offsets, field
  positions, reset values and the all-ones empty answer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package imqp_pkg;
  localparam logic [11:0] OFF_OP_STATUS = 12'h030;
  localparam logic [11:0] OFF_OP_MASK   = 12'h034;
  localparam logic [11:0] OFF_INQ       = 12'h040;
  localparam logic [11:0] OFF_OUTQ      = 12'h044;
  localparam int          BIT_OP_SR     = 3;
  localparam int          BIT_OUTPOST_IRQ_MASK     = 3;
  localparam logic        RST_OUTPOST_IRQ_MASK     = 1'h1;
  localparam logic [31:0] EMPTY_WORD    = 32'hffffffff;
  localparam logic [31:0] RST_WORD      = 32'h00000000;
  localparam logic [1:0]  LIST_IN_POST  = 2'h0;
  localparam logic [1:0]  LIST_IN_FREE  = 2'h1;
  localparam logic [1:0]  LIST_OUT_POST = 2'h2;
  localparam logic [1:0]  LIST_OUT_FREE = 2'h3;
endpackage
`default_nettype wire

// file: src/imqp_buf2.sv
/*
  Two-entry valid/ready buffer carrying forwarded post writes.
  Assumes a single clock and an active-low asynchronous reset.
*/
`default_nettype none
module imqp_buf2 #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem [2];
  logic         rd_ptr;
  logic         wr_ptr;
  logic [1:0]   count;
  logic         do_wr;
  logic         do_rd;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_ptr <= 1'h0;
      wr_ptr <= 1'h0;
      count  <= 2'h0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= ~wr_ptr;
      if (do_rd)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'h0, do_wr} - {1'h0, do_rd};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (do_wr)
      mem[wr_ptr] <= in_data;
  end
endmodule
`default_nettype wire

// file: bench/imqp_port_assertions.sv
/*
  Checker for the message-queue port, watching the top module's ports only.
  Assumes one clock, active-low async reset, package imqp_pkg compiled first.
*/
`default_nettype none
module imqp_port_assertions #(
  parameter int AW    = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic          clk_sys,
  input wire logic          arst_n,
  // host register port
  input wire logic          reg_wr,
  input wire logic [11:0]   reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic          reg_done,
  input wire logic          reg_retry,
  input wire logic [31:0]   reg_rdata,
  input wire logic [AW-1:0] out_post_base,
  // local memory port
  input wire logic          mem_req,
  input wire logic          mem_wr,
  input wire logic [AW-1:0] mem_addr,
  input wire logic [31:0]   mem_wdata,
  input wire logic          mem_ack,
  input wire logic          outpost_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mask_r;
  logic posted;
  wire logic qadr = reg_addr == imqp_pkg::OFF_INQ || reg_addr == imqp_pkg::OFF_OUTQ;
  wire logic opost = mem_addr >= out_post_base && mem_addr < out_post_base + AW'(4 * DEPTH);

  //////////////////////////////////////////////////////////////////////////
  // shadow of mask and outbound post occupancy
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      mask_r <= imqp_pkg::RST_OUTPOST_IRQ_MASK;
    else if (reg_done && reg_wr && reg_addr == imqp_pkg::OFF_OP_MASK)
      mask_r <= reg_wdata[imqp_pkg::BIT_OUTPOST_IRQ_MASK];

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      posted <= 1'h0;
    else if (mem_req && mem_ack && mem_wr && opost)
      posted <= 1'h1;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_answer_one_cycle: assert property (reg_done || reg_retry |=> !reg_done && !reg_retry)
    else $error("answer longer than one cycle");
  a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_wr) && $stable(mem_wdata)) else $error("memory request not held");
  a_req_released: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request not released");
  a_post_forwarded: assert property (reg_done && reg_wr && qadr |-> ##[1:30] mem_req && mem_wr)
    else $error("queue write not forwarded");
  a_empty_all_ones: assert property (reg_done && !reg_wr && qadr
    |-> reg_rdata == imqp_pkg::EMPTY_WORD) else $error("empty free list read wrong");
  a_irq_masked: assert property (mask_r [*3] |-> !outpost_irq)
    else $error("interrupt while masked");
  a_irq_raised: assert property ((posted && !mask_r) [*3] |-> outpost_irq)
    else $error("interrupt missing");
  a_status_bit: assert property (reg_done && !reg_wr && reg_addr == imqp_pkg::OFF_OP_STATUS
    |-> reg_rdata[imqp_pkg::BIT_OP_SR] == $past(posted)) else $error("service request bit wrong");

  c_retry: cover property (reg_retry);
  c_irq: cover property (outpost_irq);
  c_write_ack: cover property (mem_req && mem_ack && mem_wr);
endmodule

bind imqp_port imqp_port_assertions #(.AW(AW), .DEPTH(DEPTH)) u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_done(reg_done), .reg_retry(reg_retry), .reg_rdata(reg_rdata),
  .out_post_base(out_post_base), .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .outpost_irq(outpost_irq));
`default_nettype wire

// file: bench/imqp_mem_model.sv
/*
  Local memory model answering the port's requests, promptly or slowly.
  Assumes one clock and an active-low async reset; records the last write.
*/
`default_nettype none
module imqp_mem_model (
  // clock and reset
  input wire logic         clk_sys,
  input wire logic         arst_n,
  // memory port
  input wire logic         mem_req,
  input wire logic         mem_wr,
  input wire logic [31:0]  mem_addr,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  input wire logic [31:0]  mem_wdata,
  // test control and observation
  input wire logic         slow,
  output logic [31:0]      wr_addr,
  output logic [31:0]      wr_data,
  output int               wr_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_n;

  // off the ack cycle the data lines toggle
  assign mem_rdata = mem_ack ? ~mem_addr : 32'(wait_n) ^ 32'hffff0000;

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      mem_ack <= 1'h0;
      wait_n <= 0;
      wr_cnt <= 0;
      wr_addr <= 32'h0;
      wr_data <= 32'h0;
    end
    else if (mem_ack)
    begin
      mem_ack <= 1'h0;
      wait_n <= 0;
    end
    else if (mem_req && wait_n >= (slow ? 6 : 0))
    begin
      mem_ack <= 1'h1;
      if (mem_wr)
      begin
        wr_cnt <= wr_cnt + 1;
        wr_addr <= mem_addr;
        wr_data <= mem_wdata;
      end
    end
    else if (mem_req)
      wait_n <= wait_n + 1;
endmodule
`default_nettype wire

// file: bench/testbench.sv
/*
  Testbench for the message-queue port: register calls with expected values.
  Assumes the memory model beside it and the checker bound into the port.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'h0;
  logic        arst_n, reg_sel, reg_wr, reg_done, reg_retry, mem_req, mem_wr, mem_ack;
  logic        outpost_irq, slow;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, wr_addr, wr_data, rd;
  int          wr_cnt, errors = 0, checks = 0, cycles = 0, nretry;

  always #5 clk_sys = ~clk_sys;

  imqp_port dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_done(reg_done), .reg_retry(reg_retry),
    .reg_rdata(reg_rdata), .in_post_base(32'h00001000), .in_free_base(32'h00002000),
    .out_post_base(32'h00003000), .out_free_base(32'h00004000), .mem_req(mem_req),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .outpost_irq(outpost_irq));
  imqp_mem_model u_mem (.clk_sys(clk_sys), .arst_n(arst_n), .mem_req(mem_req),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_wdata(mem_wdata), .slow(slow), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_cnt(wr_cnt));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one access, repeated while refused
  // host repeats retried access
  task automatic xfer(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
    logic rt;
    nretry = -1;
    do
    begin
      nretry++;
      @(negedge clk_sys);
      reg_sel = 1'h1;
      reg_wr = wr;
      reg_addr = adr;
      reg_wdata = wd;
      do @(negedge clk_sys); while (reg_done !== 1'h1 && reg_retry !== 1'h1);
      rd = reg_rdata;
      rt = reg_retry;
      @(negedge clk_sys);
      reg_sel = 1'h0;
    end
    while (rt);
  endtask

  task automatic wait_wr(input int n);
    while (wr_cnt < n) @(negedge clk_sys);
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      stop_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    arst_n = 1'h0;
    reg_sel = 1'h0;
    reg_wr = 1'h0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    slow = 1'h0;
    repeat (16) @(negedge clk_sys);
    arst_n = 1'h1;
    xfer(1'h0, imqp_pkg::OFF_OP_STATUS, 32'h0); check(rd, 32'h0);
    xfer(1'h0, imqp_pkg::OFF_OP_MASK, 32'h0); check(rd, 32'h8);
    xfer(1'h0, imqp_pkg::OFF_INQ, 32'h0); check(rd, imqp_pkg::EMPTY_WORD);
    xfer(1'h0, imqp_pkg::OFF_OUTQ, 32'h0); check(rd, imqp_pkg::EMPTY_WORD);
    xfer(1'h0, 12'h0fc, 32'h0); check(rd, 32'h0);
    slow = 1'h1;
    xfer(1'h1, imqp_pkg::OFF_INQ, 32'ha5a50001);
    xfer(1'h1, imqp_pkg::OFF_INQ, 32'h5aa50002); check(32'(nretry > 0), 32'h1);
    wait_wr(2);
    check(wr_addr, 32'h00001004);
    check(wr_data, 32'h5aa50002);
    xfer(1'h1, imqp_pkg::OFF_OUTQ, 32'hc3c30003);
    wait_wr(3);
    check(wr_addr, 32'h00003000);
    repeat (4) @(negedge clk_sys);
    check(32'(outpost_irq), 32'h0);
    xfer(1'h0, imqp_pkg::OFF_OP_STATUS, 32'h0); check(rd, 32'h8);
    xfer(1'h1, imqp_pkg::OFF_OP_MASK, 32'h0);
    repeat (4) @(negedge clk_sys);
    check(32'(outpost_irq), 32'h1);
    xfer(1'h1, imqp_pkg::OFF_OP_MASK, 32'h8);
    repeat (4) @(negedge clk_sys);
    check(32'(outpost_irq), 32'h0);
    xfer(1'h1, imqp_pkg::OFF_OP_MASK, 32'h0);
    @(negedge clk_sys);
    arst_n = 1'h0;
    repeat (2) @(negedge clk_sys);
    arst_n = 1'h1;
    xfer(1'h0, imqp_pkg::OFF_OP_MASK, 32'h0); check(rd, 32'h8);
    xfer(1'h0, imqp_pkg::OFF_OP_STATUS, 32'h0); check(rd, 32'h0);
    check(32'(outpost_irq), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
